// ### vip_pkg.sv
/*
 * Package for the vectored interrupt prioritizer: register offsets, field
 * positions, reset values and the vector arithmetic constants.
 * Assumes a single core clock domain and a simple strobe register port.
 */
// Overview of operation
// - Vectored mode needs support=1, ext=0, spacing nonzero, special=1, boot=0.
// - Each of eight hardware lines is an independent request, never encoded.
// - Qualified request is pending bit AND its mask bit, all ten positions.
// - Interrupt when any qualified, enable set, exception and error levels clear.
// - Hardware line 7 highest; lines 7..0 give vectors 9..2.
// - Software requests rank below hardware; soft 1 gives 1, soft 0 gives 0.
// - Among several requests, output the single highest-priority vector number.
// - Each vector may select a shadow register set for its handler.
// - Offset is vector times spacing times 32 bytes, added to base 0x200.
// - Vector numbers in vectored mode lie only in 0..9.
// - Spacing resets to zero; zero means compatibility mode.
`default_nettype none

package vip_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL     = 4'h0; // spacing, special, boot, enable, levels
	localparam logic [3:0] ADDR_MASK     = 4'h1; // per-line mask bits
	localparam logic [3:0] ADDR_SOFT     = 4'h2; // two software requests
	localparam logic [3:0] ADDR_STATUS   = 4'h3; // pending bits, vector, mode
	localparam logic [3:0] ADDR_OFFSET   = 4'h4; // exception vector offset
	localparam logic [3:0] ADDR_SHADOW   = 4'h5; // shadow map, vectors 0..7
	localparam logic [3:0] ADDR_SHADOW_H = 4'h6; // shadow map, vectors 8..9
	localparam logic [3:0] ADDR_CONFIG   = 4'h7; // support flags, timer line

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int CTRL_VS_LSB  = 0;  // spacing field [4:0]
	localparam int CTRL_IV_BIT  = 8;  // special vector select
	localparam int CTRL_BEV_BIT = 9;  // boot vector select
	localparam int CTRL_IE_BIT  = 10; // global enable
	localparam int CTRL_EXL_BIT = 11; // exception level
	localparam int CTRL_ERL_BIT = 12; // error level

	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int NUM_REQ = 10;
	localparam int NUM_HW  = 8;
	localparam logic [4:0]  VS_RST     = 5'h00;
	localparam logic        IV_RST     = 1'b0;
	localparam logic        BEV_RST    = 1'b1;
	localparam logic [9:0]  MASK_RST   = 10'h000;
	localparam logic [29:0] SHADOW_RST = 30'h0000_0000;
	localparam logic        VECTORED_SUPPORT_FLAG_FLAG  = 1'b1;   // vectored support always present
	localparam logic [2:0]  TIMER_LINE = 3'h7;   // hardware line carrying the timer
	localparam logic [15:0] VEC_BASE   = 16'h0200;
	localparam logic [15:0] COMPAT_OFS = 16'h0180;
	localparam logic [3:0]  VEC_MAX    = 4'h9;
endpackage : vip_pkg

`default_nettype wire

// ### vip_prio_enc.sv
/*
 * Fixed-priority encoder over ten qualified requests.
 * Assumes requests arrive already qualified and synchronous.
 */
`default_nettype none

module vip_prio_enc (
	// Qualified requests, bit 9 is hardware line 7
	input  wire logic [9:0] req_in,
	// Encoded result
	output logic            any_out,
	output logic [3:0]      vec_out
);
	import vip_pkg::*;

	// Scan from bit 0 upward; a later set bit overwrites, so the highest set bit wins
	always_comb begin
		any_out = |req_in;
		vec_out = 4'h0;
		for (int i = 0; i < NUM_REQ; i++) begin
			if (req_in[i]) begin
				vec_out = 4'(i);
			end
		end
	end
endmodule : vip_prio_enc

`default_nettype wire

// ### vip_sync.sv
/*
 * Two-flop synchroniser bank for the eight hardware request pins.
 * Assumes the pins are asynchronous to the core clock.
 */
`default_nettype none

module vip_sync (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       ce_in,
	// Raw and synchronised lines
	input  wire logic [7:0] d_in,
	output logic [7:0]      q_out
);
	typedef struct packed {
		logic [7:0] meta;
		logic [7:0] sync;
	} vip_sync_s;

	vip_sync_s st_ff;
	vip_sync_s nxt_st;

	// First stage feeds only the second stage
	always_comb begin
		nxt_st = st_ff;
		if (ce_in) begin
			nxt_st.meta = d_in;
			nxt_st.sync = st_ff.meta;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q_out = st_ff.sync;
endmodule : vip_sync

`default_nettype wire

// ### vip_top.sv
/*
 * Vectored interrupt prioritizer: masks and gates ten requests, picks the
 * highest one, forms the vector offset and shadow set, registers results.
 * Assumes the timer is already merged into a hardware line outside.
 */
`default_nettype none

module vip_top (
	// Clock, reset, enable
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        ce_in,
	// Static strap
	input  wire logic        ext_controller_support_flag_in,
	// Hardware request lines
	input  wire logic [7:0]  hw_line_in,
	// Register port
	input  wire logic [3:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic [31:0]      rdata_out,
	// Pipeline side
	output logic             irq_out,
	output logic [3:0]       vector_out,
	output logic [15:0]      vec_offset_out,
	output logic [2:0]       shadow_set_out,
	output logic             vectored_mode_out
);
	import vip_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [4:0]  vector_spacing;
		logic        special_vector_select;
		logic        boot_vector_select;
		logic        global_irq_enable;
		logic        exception_level_bit;
		logic        error_level_bit;
		logic [9:0]  line_mask_bits;
		logic [1:0]  soft_req;
		logic [29:0] shadow_map;      // 3 bits per vector
		logic        ext_flag;
		logic        irq;
		logic [3:0]  vec;
		logic [15:0] ofs;
		logic [2:0]  shadow;
		logic        vmode;
		logic [31:0] rdata;
	} vip_top_s;

	vip_top_s st_ff;
	vip_top_s nxt_st;

	logic [7:0] hw_sync;
	logic [9:0] pending_request_bits;
	logic [9:0] qualified;
	logic       any_req;
	logic [3:0] enc_vec;
	logic       vmode;
	logic       irq_en;

	// Pins cross into the core clock first
	vip_sync u_sync (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.ce_in   (ce_in),
		.d_in    (hw_line_in),
		.q_out   (hw_sync)
	);

	// ------------------------------------------------------------
	// Request qualification
	// ------------------------------------------------------------
	// Lines stay separate bits; no encoding of the hardware field
	assign pending_request_bits = {hw_sync, st_ff.soft_req};
	assign qualified = pending_request_bits & st_ff.line_mask_bits;

	vip_prio_enc u_enc (
		.req_in  (qualified),
		.any_out (any_req),
		.vec_out (enc_vec)
	);

	// Mode decode; zero spacing falls back to compatibility
	assign vmode = VECTORED_SUPPORT_FLAG_FLAG && !st_ff.ext_flag && (st_ff.vector_spacing != 5'h00)
		&& st_ff.special_vector_select && !st_ff.boot_vector_select;

	assign irq_en = st_ff.global_irq_enable && !st_ff.exception_level_bit
		&& !st_ff.error_level_bit;

	// Offset arithmetic: vector scaled by spacing times 32 bytes
	function automatic logic [15:0] vip_vec_ofs(input logic [3:0] v, input logic [4:0] vs);
		logic [15:0] prod;
		prod = 16'(16'(v) * 16'(vs));
		return VEC_BASE + 16'(prod << 5);
	endfunction : vip_vec_ofs

	// Shadow set lookup for a vector
	function automatic logic [2:0] vip_shadow(input logic [29:0] map, input logic [3:0] v);
		logic [2:0] s;
		s = 3'h0;
		for (int i = 0; i < NUM_REQ; i++) begin
			if (v == 4'(i)) begin
				s = map[3*i +: 3];
			end
		end
		return s;
	endfunction : vip_shadow

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		if (ce_in) begin
			// Register writes
			if (wr_in) begin
				unique case (addr_in)
					ADDR_CTRL: begin
						nxt_st.vector_spacing        = wdata_in[CTRL_VS_LSB +: 5];
						nxt_st.special_vector_select = wdata_in[CTRL_IV_BIT];
						nxt_st.boot_vector_select    = wdata_in[CTRL_BEV_BIT];
						nxt_st.global_irq_enable     = wdata_in[CTRL_IE_BIT];
						nxt_st.exception_level_bit   = wdata_in[CTRL_EXL_BIT];
						nxt_st.error_level_bit       = wdata_in[CTRL_ERL_BIT];
					end
					ADDR_MASK: nxt_st.line_mask_bits = wdata_in[9:0];
					ADDR_SOFT: nxt_st.soft_req = wdata_in[1:0];
					ADDR_SHADOW: nxt_st.shadow_map[23:0] = wdata_in[23:0];
					ADDR_SHADOW_H: nxt_st.shadow_map[29:24] = wdata_in[5:0];
					default: begin
					end
				endcase
			end
			// Reads: data stands the cycle after the strobe, then clears; held while the clock enable is low
			nxt_st.rdata = 32'h0000_0000;
			if (rd_in) begin
				unique case (addr_in)
					ADDR_CTRL: nxt_st.rdata = {19'h0, st_ff.error_level_bit,
						st_ff.exception_level_bit, st_ff.global_irq_enable,
						st_ff.boot_vector_select, st_ff.special_vector_select,
						3'h0, st_ff.vector_spacing};
					ADDR_MASK: nxt_st.rdata = {22'h0, st_ff.line_mask_bits};
					ADDR_SOFT: nxt_st.rdata = {30'h0, st_ff.soft_req};
					ADDR_STATUS: nxt_st.rdata = {11'h0, st_ff.vmode, st_ff.vec,
						st_ff.irq, 5'h0, pending_request_bits};
					ADDR_OFFSET: nxt_st.rdata = {16'h0, st_ff.ofs};
					ADDR_SHADOW: nxt_st.rdata = {8'h0, st_ff.shadow_map[23:0]};
					ADDR_SHADOW_H: nxt_st.rdata = {26'h0, st_ff.shadow_map[29:24]};
					ADDR_CONFIG: nxt_st.rdata = {24'h0, 1'b0, TIMER_LINE,
						2'h0, st_ff.ext_flag, VECTORED_SUPPORT_FLAG_FLAG};
					default: nxt_st.rdata = 32'h0000_0000;
				endcase
			end
			// Strap is steady; sample it each clock-enabled cycle after reset release
			nxt_st.ext_flag = ext_controller_support_flag_in;
			// Registered request and matching vector, same cycle
			nxt_st.vmode  = vmode;
			nxt_st.irq    = any_req && irq_en;
			nxt_st.vec    = (enc_vec > VEC_MAX) ? VEC_MAX : enc_vec;
			nxt_st.ofs    = vmode ? vip_vec_ofs(enc_vec, st_ff.vector_spacing)
				: (st_ff.special_vector_select ? VEC_BASE : COMPAT_OFS);
			nxt_st.shadow = vmode ? vip_shadow(st_ff.shadow_map, enc_vec) : 3'h0;
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_ff <= '0;
			st_ff.vector_spacing        <= VS_RST;
			st_ff.special_vector_select <= IV_RST;
			st_ff.boot_vector_select    <= BEV_RST;
			st_ff.line_mask_bits        <= MASK_RST;
			st_ff.shadow_map            <= SHADOW_RST;
			st_ff.ofs                   <= COMPAT_OFS;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs from flops
	assign rdata_out         = st_ff.rdata;
	assign irq_out           = st_ff.irq;
	assign vector_out        = st_ff.vec;
	assign vec_offset_out    = st_ff.ofs;
	assign shadow_set_out    = st_ff.shadow;
	assign vectored_mode_out = st_ff.vmode;
endmodule : vip_top

`default_nettype wire

// ### vip_src_model.sv
/* Far-side request sources, with the timer merged onto one hardware line.
   Assumes the core clock domain; the pins are plain levels with no pull. */
`default_nettype none
module vip_src_model
	import vip_pkg::*;
(
	// Source requests
	input  wire logic [7:0] dev_req_in,
	input  wire logic       timer_req_in,
	// Merged pin levels
	output logic [7:0]      hw_line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// The timer rides on the indicated line, so it keeps that line's rank
	always_comb begin
		hw_line_out = dev_req_in;
		hw_line_out[TIMER_LINE] = dev_req_in[TIMER_LINE] | timer_req_in;
	end
endmodule : vip_src_model
`default_nettype wire

// ### vip_top_chk.sv
/* Checker for the prioritizer outputs against control writes and the strap.
   Assumes it is bound to vip_top and sees only its ports. */
`default_nettype none
module vip_top_chk
	import vip_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rstn_in,
	input wire logic        ce_in,
	input wire logic        ext_controller_support_flag_in,
	input wire logic [7:0]  hw_line_in,
	input wire logic [3:0]  addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic        irq_out,
	input wire logic [3:0]  vector_out,
	input wire logic [15:0] vec_offset_out,
	input wire logic [2:0]  shadow_set_out,
	input wire logic        vectored_mode_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Control writes that must shut the gate or leave vectored mode
	sequence s_gate_shut;
		wr_in && ce_in && addr_in == ADDR_CTRL && (!wdata_in[CTRL_IE_BIT]
			|| wdata_in[CTRL_EXL_BIT] || wdata_in[CTRL_ERL_BIT]) ##1 ce_in && !wr_in;
	endsequence
	sequence s_mode_off;
		wr_in && ce_in && addr_in == ADDR_CTRL && (wdata_in[4:0] == 5'h00
			|| !wdata_in[CTRL_IV_BIT] || wdata_in[CTRL_BEV_BIT]) ##1 ce_in && !wr_in;
	endsequence
	a_gate_blocks_irq: assert property (s_gate_shut |=> !irq_out)
		else $error("irq high after gate closed");
	a_fields_gate_mode: assert property (s_mode_off |=> !vectored_mode_out)
		else $error("vectored mode with bad control fields");
	a_strap_blocks_mode: assert property ((ext_controller_support_flag_in && ce_in) [*2]
		|=> !vectored_mode_out)
		else $error("vectored mode with external controller strap");
	a_vector_in_range: assert property (vector_out <= VEC_MAX)
		else $error("vector out of range");
	// Clearing every mask bit leaves nothing for the encoder to pick
	sequence s_mask_clear;
		wr_in && ce_in && addr_in == ADDR_MASK && wdata_in[9:0] == 10'h000
			##1 ce_in && !wr_in;
	endsequence
	a_no_req_no_vec: assert property (s_mask_clear |=> !irq_out && vector_out == 4'h0)
		else $error("vector or request with every line masked");
	a_offset_compat: assert property (!vectored_mode_out
		|-> vec_offset_out == VEC_BASE || vec_offset_out == COMPAT_OFS)
		else $error("bad compatibility offset");
	a_offset_vectored: assert property (vectored_mode_out
		|-> vec_offset_out[4:0] == 5'h00 && vec_offset_out >= VEC_BASE)
		else $error("bad vectored offset");
	a_shadow_compat: assert property (!vectored_mode_out |-> shadow_set_out == 3'h0)
		else $error("shadow set outside vectored mode");
	a_frozen_outputs: assert property (!ce_in |=> $stable(irq_out) && $stable(vector_out))
		else $error("outputs moved with clock enable low");
	a_read_data_once: assert property ($past(ce_in) && !$past(rd_in) |-> rdata_out == 32'h0)
		else $error("read data outside its cycle");
endmodule : vip_top_chk
bind vip_top vip_top_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
	.ext_controller_support_flag_in(ext_controller_support_flag_in), .hw_line_in(hw_line_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.irq_out(irq_out), .vector_out(vector_out), .vec_offset_out(vec_offset_out),
	.shadow_set_out(shadow_set_out), .vectored_mode_out(vectored_mode_out));
`default_nettype wire

// ### vectored_interrupt_prioritizer_tb.sv
/* Self-checking bench for the vectored interrupt prioritizer.
   Assumes the checker binds itself and the source model drives the pins. */
`default_nettype none
module vectored_interrupt_prioritizer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import vip_pkg::*;
	localparam logic [31:0] CTRL_ON = 32'h0000_0501; // spacing 1, special, enable
	logic        clk_in    = 1'b0;
	logic        rstn_in   = 1'b0;
	logic        ce_in     = 1'b1;
	logic        ext_strap = 1'b0;
	logic [7:0]  dev_req   = 8'h00;
	logic        timer_req = 1'b0;
	logic [3:0]  addr_in   = 4'h0;
	logic [31:0] wdata_in  = 32'h0;
	logic        wr_in     = 1'b0;
	logic        rd_in     = 1'b0;
	logic [7:0]  hw_line;
	logic [31:0] rdata_out, rd_val;
	logic        irq_out, vectored_mode_out;
	logic [3:0]  vector_out;
	logic [15:0] vec_offset_out;
	logic [2:0]  shadow_set_out;
	int          miscompares  = 0;
	int          total_checks = 0;
	always #5 clk_in = ~clk_in;
	vip_src_model u_src (.dev_req_in(dev_req), .timer_req_in(timer_req), .hw_line_out(hw_line));
	vip_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
		.ext_controller_support_flag_in(ext_strap), .hw_line_in(hw_line), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.irq_out(irq_out), .vector_out(vector_out), .vec_offset_out(vec_offset_out),
		.shadow_set_out(shadow_set_out), .vectored_mode_out(vectored_mode_out));
	// ------------------------------------------------------------
	// Compare and bus tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_pipe(input logic i, input logic [3:0] v, input logic [15:0] o, input logic m);
		chk({10'h0, irq_out, vector_out, vec_offset_out, vectored_mode_out}, {10'h0, i, v, o, m});
	endtask : chk_pipe
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr_in    <= 1'b1;
		addr_in  <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_in);
		rd_in   <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : rd
	// Pins need three edges through the synchroniser, so four is safe
	task automatic set_req(input logic [9:0] r);
		@(posedge clk_in);
		dev_req <= r[9:2];
		wr(ADDR_SOFT, {30'h0, r[1:0]});
		repeat (4) @(posedge clk_in);
		#1;
	endtask : set_req
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values;
		chk_pipe(1'b0, 4'h0, COMPAT_OFS, 1'b0);
		rd(ADDR_CTRL, rd_val);
		chk(rd_val, 32'h0000_0200);
		wr(ADDR_CONFIG, 32'h0);
		rd(ADDR_CONFIG, rd_val);
		chk(rd_val, 32'h0000_0071);
		rd(4'h8, rd_val);
		chk(rd_val, 32'h0);
	endtask : t_reset_values
	// Every position with all lower ones, then on its own with its mask bit clear, spacing varied
	task automatic t_priority;
		for (int i = 0; i < 10; i++) begin
			wr(ADDR_CTRL, 32'h0000_0500 | (i + 1));
			wr(ADDR_MASK, 32'h3ff);
			set_req(10'((1 << (i + 1)) - 1));
			chk_pipe(1'b1, 4'(i), VEC_BASE + 16'(i * (i + 1) * 32), 1'b1);
			wr(ADDR_MASK, 32'h3ff & ~(32'h1 << i));
			set_req(10'(1 << i));
			chk_pipe(1'b0, 4'h0, VEC_BASE, 1'b1);
		end
	endtask : t_priority
	task automatic t_gating_modes;
		logic [31:0] ctl [7] = '{32'h101, 32'hd01, 32'h1501, 32'h500, 32'h401, 32'h701, CTRL_ON};
		logic [15:0] ofs [7] = '{16'h200, 16'h200, 16'h200, 16'h200, 16'h180, 16'h200, 16'h200};
		logic        irq [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
		wr(ADDR_MASK, 32'h3ff);
		set_req(10'h001);
		for (int k = 0; k < 7; k++) begin
			wr(ADDR_CTRL, ctl[k]);
			set_req(10'h001);
			chk_pipe(irq[k], 4'h0, ofs[k], k < 3 || k == 6);
		end
		@(posedge clk_in);
		ext_strap <= 1'b1;
		set_req(10'h001);
		chk_pipe(1'b1, 4'h0, VEC_BASE, 1'b0);
		@(posedge clk_in);
		ext_strap <= 1'b0;
	endtask : t_gating_modes
	task automatic t_shadow;
		wr(ADDR_SHADOW, 32'h5);
		wr(ADDR_SHADOW_H, 32'h30);
		set_req(10'h001);
		chk({29'h0, shadow_set_out}, 32'h5);
		set_req(10'h201);
		chk({29'h0, shadow_set_out}, 32'h6);
		rd(ADDR_SHADOW_H, rd_val);
		chk(rd_val, 32'h30);
	endtask : t_shadow
	// Timer raised while the clock enable is low must not get in
	task automatic t_timer_freeze;
		set_req(10'h000);
		@(posedge clk_in);
		ce_in     <= 1'b0;
		timer_req <= 1'b1;
		repeat (5) @(posedge clk_in);
		#1 chk_pipe(1'b0, 4'h0, VEC_BASE, 1'b1);
		@(posedge clk_in);
		ce_in <= 1'b1;
		set_req(10'h000);
		chk_pipe(1'b1, 4'h9, VEC_BASE + 16'h120, 1'b1);
		// Masking every line must drop the timer request and its vector
		wr(ADDR_MASK, 32'h0);
		@(posedge clk_in);
		#1 chk_pipe(1'b0, 4'h0, VEC_BASE, 1'b1);
	endtask : t_timer_freeze
	task automatic tally_and_finish;
		if (miscompares == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	// Watchdog: a hang counts as a failure
	initial begin
		#200000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk_in);
		rstn_in <= 1'b1;
		@(posedge clk_in);
		#1 t_reset_values;
		t_priority;
		t_gating_modes;
		t_shadow;
		t_timer_freeze;
		tally_and_finish;
	end
endmodule : vectored_interrupt_prioritizer_tb
`default_nettype wire
